// ### axi_lite_master_model.sv
// register-bus master standing in for the fetch and execute side
`timescale 1ns/1ps
`default_nettype none
module axi_lite_master_model (
   input  wire logic        clk_in,
   output var logic [7:0]  s_axi_awaddr,
   output var logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0]  s_axi_wstrb,
   output var logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output var logic        s_axi_bready,
   output var logic [7:0]  s_axi_araddr,
   output var logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output var logic        s_axi_rready
);
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
   initial {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 14'h000F;
   // channels released on their own take; payload inverted after release so stale values never match
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      fork
         begin do @(posedge clk_in); while (!s_axi_awready); s_axi_awvalid <= 1'b0; s_axi_awaddr <= ~a; end
         begin do @(posedge clk_in); while (!s_axi_wready); s_axi_wvalid <= 1'b0; s_axi_wdata <= ~d; end
      join
      while (!s_axi_bvalid) @(posedge clk_in);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do @(posedge clk_in); while (!s_axi_arready);
      {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
      while (!s_axi_rvalid) @(posedge clk_in);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### barrel_shifter.sv
// 40-bit arithmetic accumulator shifter, negative count shifts left
`timescale 1ns/1ps
`default_nettype none
module barrel_shifter (
   input  wire logic        ref_clk_in,  // core clock
   input  wire logic        rst_in,      // sync reset
   input  wire logic [39:0] acc_in,      // accumulator value
   input  wire logic [5:0]  count_in,    // signed shift count
   output logic      [39:0] acc_out      // shifted accumulator
);
   logic [5:0] mag; // shift magnitude
   always_comb begin
      mag = count_in[5] ? 6'(-count_in) : count_in;
   end
   // ----------------------------------------------------------------
   // shift register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         acc_out <= 40'h00_0000_0000;
      end else if (count_in[5]) begin
         acc_out <= acc_in << mag;
      end else begin
         acc_out <= 40'($signed(acc_in) >>> mag);
      end
   end
endmodule
`default_nettype wire

// ### exponent_unit.sv
// exponent unit: first bit change from the sign bit, negated count
`timescale 1ns/1ps
`default_nettype none
module exponent_unit (
   input  wire logic        ref_clk_in,  // core clock
   input  wire logic        rst_in,      // sync reset
   input  wire logic [15:0] operand_in,  // signed word to scan
   output logic      [4:0]  exp_out      // two's complement -15..0
);
   // ----------------------------------------------------------------
   // scan
   // ----------------------------------------------------------------
   // position of first bit differing from the sign, from bit 14 down
   function automatic logic [4:0] find_first_change_left(input logic [15:0] w);
      logic [4:0] cnt;
      logic       done;
      cnt  = 5'h00;
      done = 1'b0;
      for (int i = 14; i >= 0; i--) begin
         if (!done && (w[i] != w[15])) begin
            done = 1'b1;
         end else if (!done) begin
            cnt = cnt + 5'h01;
         end
      end
      // all bits equal to the sign: cannot be scaled, clamp at 15
      if (!done) begin
         cnt = 5'h0F;
      end
      return 5'(-cnt); // negated so the shifter reads it as a left shift
   endfunction
   // one cycle result register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         exp_out <= 5'h00;
      end else begin
         exp_out <= find_first_change_left(operand_in);
      end
   end
endmodule
`default_nettype wire

// ### opdec_pkg.sv
// types shared by the operand-field decoder files
package opdec_pkg;
   // source / destination addressing modes
   typedef enum logic [2:0] {
      MODE_DIRECT, MODE_INDIRECT, MODE_POST_DEC, MODE_POST_INC,
      MODE_PRE_DEC, MODE_PRE_INC, MODE_REG_OFFSET, MODE_UNUSED
   } addr_mode_t;
   // accumulator write-back selection
   typedef enum logic [1:0] {
      WB_DIRECT, WB_POST_INC, WB_NONE, WB_INVALID
   } wb_mode_t;
   // bus slave state
   typedef enum logic [1:0] {
      BUS_IDLE, BUS_RESP
   } bus_state_t;
endpackage

// ### opdec_regs.svh
// constants for the operand-field decoder, exponent unit and register bus
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_INSTR_LO     8'h00
`define REG_INSTR_HI     8'h04
`define REG_CTRL         8'h08
`define REG_OPERAND      8'h0C
`define REG_ACC_A_LO     8'h10
`define REG_ACC_A_HI     8'h14
`define REG_ACC_B_LO     8'h18
`define REG_ACC_B_HI     8'h1C
`define REG_CTL_OUT      8'h20
`define REG_ADDR_OUT     8'h24
`define REG_LIT_OUT      8'h28
`define REG_EXP_OUT      8'h2C
`define REG_SHIFT_OUT    8'h30
`define REG_STORE_OUT    8'h34
`define REG_PREFETCH_OUT 8'h38
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_EXP_SRC_BIT 0
`define CTRL_ACC_SEL_BIT 1
`define CTRL_LIT_SEL_LSB 4
`define CTRL_EXP_DST_LSB 8
// ----------------------------------------------------------------
// instruction word fields (24-bit word, low part)
// ----------------------------------------------------------------
`define FLD_ACC_BIT      15
`define FLD_SIZE_BIT     14
`define FLD_DWORD_BIT    6
`define FLD_DEST_BIT     13
`define FLD_ZTEST_BIT    0
`define FLD_DST_MODE_LSB 11
`define FLD_DST_REG_LSB  7
`define FLD_BASE_REG_LSB 15
`define FLD_SRC_MODE_LSB 4
`define FLD_SRC_REG_LSB  0
`define FLD_BITPOS_LSB   12
`define FLD_WB_LSB       0
`define FLD_PFX_LSB      6
// ----------------------------------------------------------------
// numeric limits and reset values
// ----------------------------------------------------------------
`define EXP_MIN          5'h11
`define ACC_WIDTH        40
`define CTRL_RESET       32'h0000_0000
`endif

// ### operand_field_decode.sv
// operand-field decoder with exponent unit, on an AXI4-Lite slave
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "opdec_regs.svh"
module operand_field_decode (
   input  wire logic        ref_clk_in,        // 20 MHz core clock
   input  wire logic        rst_in,            // sync reset, high
   input  wire logic [7:0]  s_axi_awaddr,      // write address
   input  wire logic        s_axi_awvalid,     // write address valid
   output logic             s_axi_awready,     // write address ready
   input  wire logic [31:0] s_axi_wdata,       // write data
   input  wire logic [3:0]  s_axi_wstrb,       // byte strobes
   input  wire logic        s_axi_wvalid,      // write data valid
   output logic             s_axi_wready,      // write data ready
   output logic [1:0]       s_axi_bresp,       // write response
   output logic             s_axi_bvalid,      // write response valid
   input  wire logic        s_axi_bready,      // write response ready
   input  wire logic [7:0]  s_axi_araddr,      // read address
   input  wire logic        s_axi_arvalid,     // read address valid
   output logic             s_axi_arready,     // read address ready
   output logic [31:0]      s_axi_rdata,       // read data
   output logic [1:0]       s_axi_rresp,       // read response
   output logic             s_axi_rvalid,      // read data valid
   input  wire logic        s_axi_rready,      // read data ready
   output logic             core_reset_req_out // destination 11x trap
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [31:0] instr_lo;          // first instruction word (24 bits used)
   logic [31:0] instr_hi;          // second word, its unused field ignored
   logic [31:0] ctrl;              // steering bits
   logic [15:0] operand;           // exponent operand written by software
   logic [39:0] acc [2];           // two accumulators, index by select
   logic [4:0]  exp_raw;           // exponent unit result
   logic [39:0] shifted;           // shifter result
   logic [15:0] default_work_register [16];         // working registers receiving exponent
   logic        aw_done;           // write address taken
   logic        w_done;            // write data taken
   logic [7:0]  aw_addr;           // held write address
   logic [31:0] w_data;            // held write data
   logic [3:0]  w_strb;            // held strobes
   opdec_pkg::bus_state_t rd_state; // read channel state
   // ----------------------------------------------------------------
   // decoded fields
   // ----------------------------------------------------------------
   logic        acc_sel;           // accumulator select
   logic        byte_op;           // byte-size operation
   logic        dword_op;          // double-word operation
   logic        dest_file;         // result to file register
   logic        test_to_zero;      // bit test into zero flag
   logic [3:0]  dst_reg;           // destination register number
   logic [3:0]  source_register_select; // source register number
   logic [3:0]  base_register_select;   // base register number
   logic [3:0]  bit_pos;           // selected bit position
   opdec_pkg::addr_mode_t src_mode;     // plain source mode
   opdec_pkg::addr_mode_t dst_mode;     // plain destination mode
   opdec_pkg::addr_mode_t src_off_mode; // offset-capable source mode
   opdec_pkg::addr_mode_t dst_off_mode; // offset-capable destination mode
   opdec_pkg::wb_mode_t   writeback_mode_select; // accumulator write-back
   logic        prefetch_x_on;     // x prefetch active
   logic [15:0] file_addr13;       // 13-bit file address, zero extended
   logic [15:0] word_addr;         // word address with implied zero
   logic [15:0] byte_addr;         // full byte address
   logic [23:0] prog_addr;         // absolute program address
   logic [15:0] prog_offset;       // relative displacement
   logic [15:0] literal;           // extracted literal
   logic [15:0] exp_operand;       // operand fed to exponent unit
   logic [39:0] sel_acc;           // selected accumulator
   logic [15:0] store_rounded;     // rounded store value
   logic [15:0] exp_sext;          // sign-extended exponent
   // ----------------------------------------------------------------
   // mode decode helpers
   // ----------------------------------------------------------------
   // plain mode: 11x left unused
   function automatic opdec_pkg::addr_mode_t plain_mode(input logic [2:0] c);
      return c[2:1] == 2'b11 ? opdec_pkg::MODE_UNUSED : opdec_pkg::addr_mode_t'(c);
   endfunction
   // offset mode: 101 pre-increment kept, 11x base plus offset
   function automatic opdec_pkg::addr_mode_t off_mode(input logic [2:0] c);
      return c[2:1] == 2'b11 ? opdec_pkg::MODE_REG_OFFSET : opdec_pkg::addr_mode_t'(c);
   endfunction
   // literal by width code: 0=1,1=4,2=6,3=8,4=10,5=14,others=16 bits
   function automatic logic [15:0] lit_of(input logic [2:0] sel, input logic [15:0] f);
      logic [15:0] v;
      v = f;
      unique case (sel)
         3'h0: v = {15'h0000, f[0]};
         3'h1: v = {12'h000, f[3:0]};
         3'h2: v = {10'h000, f[5:0]};
         3'h3: v = {8'h00, f[7:0]};
         3'h4: v = {6'h00, f[9:0]};
         3'h5: v = {2'h0, f[13:0]};
         3'h6: v = f;
         3'h7: v = f;
      endcase
      return v;
   endfunction
   // ----------------------------------------------------------------
   // combinational field extraction
   // ----------------------------------------------------------------
   always_comb begin
      acc_sel      = instr_lo[`FLD_ACC_BIT];
      byte_op      = instr_lo[`FLD_SIZE_BIT];
      dword_op     = instr_lo[`FLD_DWORD_BIT];
      dest_file    = instr_lo[`FLD_DEST_BIT];
      test_to_zero = instr_lo[`FLD_ZTEST_BIT];
      dst_reg      = instr_lo[`FLD_DST_REG_LSB +: 4];
      source_register_select = instr_lo[`FLD_SRC_REG_LSB +: 4];
      base_register_select   = instr_lo[`FLD_BASE_REG_LSB +: 4];
      bit_pos      = instr_lo[`FLD_BITPOS_LSB +: 4];
      src_mode     = plain_mode(instr_lo[`FLD_SRC_MODE_LSB +: 3]);
      dst_mode     = plain_mode(instr_lo[`FLD_DST_MODE_LSB +: 3]);
      src_off_mode = off_mode(instr_lo[`FLD_SRC_MODE_LSB +: 3]);
      dst_off_mode = off_mode(instr_lo[`FLD_DST_MODE_LSB +: 3]);
      writeback_mode_select = opdec_pkg::wb_mode_t'(instr_lo[`FLD_WB_LSB +: 2]);
      prefetch_x_on = instr_lo[`FLD_PFX_LSB +: 4] != 4'h4;
      file_addr13  = {3'h0, instr_lo[12:0]};
      byte_addr    = instr_lo[15:0];
      word_addr    = {instr_lo[15:1], 1'b0};
      // second word carries the upper 7 bits; its remaining bits are ignored
      prog_addr    = {1'b0, instr_hi[6:0], instr_lo[15:1], 1'b0};
      prog_offset  = instr_lo[15:0];
      literal      = lit_of(ctrl[`CTRL_LIT_SEL_LSB +: 3], instr_lo[15:0]);
   end
   // ----------------------------------------------------------------
   // exponent operand and accumulator paths
   // ----------------------------------------------------------------
   always_comb begin
      sel_acc = acc[ctrl[`CTRL_ACC_SEL_BIT]];
      // guard byte sign-extended, or the software-written operand register, as exponent operand
      if (ctrl[`CTRL_EXP_SRC_BIT]) begin
         exp_operand = {{8{sel_acc[39]}}, sel_acc[39:32]};
      end else begin
         exp_operand = operand;
      end
      // high word only, whatever the guard byte holds
      store_rounded = sel_acc[31:16] + 16'(sel_acc[15]);
      exp_sext      = {{11{exp_raw[4]}}, exp_raw};
   end
   exponent_unit u_exp (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .operand_in (exp_operand),
      .exp_out    (exp_raw)
   );
   barrel_shifter u_shift (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .acc_in     (sel_acc),
      .count_in   ({exp_raw[4], exp_raw}),
      .acc_out    (shifted)
   );
   // ----------------------------------------------------------------
   // exponent write-back into the working register file
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 16; i++) begin
            default_work_register[i] <= 16'h0000;
         end
      end else begin
         default_work_register[ctrl[`CTRL_EXP_DST_LSB +: 4]] <= exp_sext;
      end
   end
   // destination trap: unused plain destination mode requests a reset
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         core_reset_req_out <= 1'b0;
      end else begin
         core_reset_req_out <= dst_mode == opdec_pkg::MODE_UNUSED;
      end
   end
   // ----------------------------------------------------------------
   // write channel: address and data in either order
   // ----------------------------------------------------------------
   // byte-lane merge used for every writable register
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         aw_done       <= 1'b0;
         w_done        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else if (s_axi_bvalid) begin
         // response pending; both channels held closed
         if (s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_done && w_done) begin
            aw_done      <= 1'b0;
            w_done       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= `REG_ACC_B_HI) ? 2'b00 : 2'b10;
         end
      end
   end
   // register commit, the cycle both halves are held
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         instr_lo <= 32'h0000_0000;
         instr_hi <= 32'h0000_0000;
         ctrl     <= `CTRL_RESET;
         operand  <= 16'h0000;
         acc[0]   <= 40'h00_0000_0000;
         acc[1]   <= 40'h00_0000_0000;
      end else if (aw_done && w_done && !s_axi_bvalid) begin
         unique case (aw_addr)
            `REG_INSTR_LO: instr_lo <= merge(instr_lo, w_data, w_strb) & 32'h00FF_FFFF;
            `REG_INSTR_HI: instr_hi <= merge(instr_hi, w_data, w_strb);
            `REG_CTRL:     ctrl     <= merge(ctrl, w_data, w_strb);
            `REG_OPERAND:  operand  <= 16'(merge({16'h0000, operand}, w_data, w_strb));
            `REG_ACC_A_LO: acc[0][31:0]  <= merge(acc[0][31:0], w_data, w_strb);
            `REG_ACC_A_HI: acc[0][39:32] <= 8'(merge({24'h0, acc[0][39:32]}, w_data, w_strb));
            `REG_ACC_B_LO: acc[1][31:0]  <= merge(acc[1][31:0], w_data, w_strb);
            `REG_ACC_B_HI: acc[1][39:32] <= 8'(merge({24'h0, acc[1][39:32]}, w_data, w_strb));
            default: begin
               // read-only or unmapped: nothing stored
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   // read mux: fixed packings of decoded state
   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `REG_INSTR_LO: r = instr_lo;
         `REG_INSTR_HI: r = instr_hi;
         `REG_CTRL:     r = ctrl;
         `REG_OPERAND:  r = {16'h0000, operand};
         `REG_ACC_A_LO: r = acc[0][31:0];
         `REG_ACC_A_HI: r = {24'h00_0000, acc[0][39:32]};
         `REG_ACC_B_LO: r = acc[1][31:0];
         `REG_ACC_B_HI: r = {24'h00_0000, acc[1][39:32]};
         `REG_CTL_OUT:  r = {4'h0, test_to_zero, prefetch_x_on, writeback_mode_select,
                            dst_off_mode, src_off_mode, dst_mode, src_mode,
                            bit_pos, dst_reg, dest_file, dword_op, byte_op, acc_sel};
         `REG_ADDR_OUT: r = {word_addr, file_addr13 | {base_register_select,
                            source_register_select, 8'h00}};
         `REG_LIT_OUT:  r = {prog_offset, literal};
         `REG_EXP_OUT:  r = {default_work_register[ctrl[`CTRL_EXP_DST_LSB +: 4]], exp_sext};
         `REG_SHIFT_OUT: r = shifted[31:0];
         `REG_STORE_OUT: r = {byte_addr, store_rounded};
         `REG_PREFETCH_OUT: r = {8'h00, prog_addr};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rd_state      <= opdec_pkg::BUS_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         unique case (rd_state)
            opdec_pkg::BUS_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state      <= opdec_pkg::BUS_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rdata   <= read_word(s_axi_araddr);
                  s_axi_rresp   <= (s_axi_araddr <= `REG_PREFETCH_OUT &&
                                    s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
               end
            end
            opdec_pkg::BUS_RESP: begin
               if (s_axi_rready) begin
                  rd_state      <= opdec_pkg::BUS_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid  <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### operand_field_decode_properties.sv
// bus and trap checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module operand_field_decode_properties (
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        core_reset_req_out
);
   // ----------------------------------------
   // one clock domain, one reset
   // ----------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rd_done;
      s_axi_rvalid && s_axi_rready;
   endsequence
   a_reset_idle: assert property ($fell(rst_in) |-> s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid && !core_reset_req_out) else $error("bus not idle after reset");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read data dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write reopened");
   a_read_release: assert property (rd_done |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
   a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write not released");
   a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad read code");
   a_trap_on_write: assert property ($changed(core_reset_req_out) |-> $past(s_axi_bvalid)
      && !$past(s_axi_bvalid, 2)) else $error("trap moved without a write");
endmodule
bind operand_field_decode operand_field_decode_properties i_props (.ref_clk_in, .rst_in, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_reset_req_out);
`default_nettype wire

// ### operand_field_decode_tb.sv
// self-checking bench for the operand-field decoder
`timescale 1ns/1ps
`default_nettype none
`include "opdec_regs.svh"
module operand_field_decode_tb;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, trap;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, d;
   logic [3:0] ws;
   logic [1:0] bre, rre, r;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [15:0] ops[8] = '{16'h0000, 16'hFFFF, 16'h4800, 16'h0001, 16'h0100, 16'hE001, 16'h8000, 16'hFF07};
   logic [15:0] exps[8] = '{16'hFFF1, 16'hFFF1, 16'h0000, 16'hFFF2, 16'hFFFA, 16'hFFFE, 16'h0000, 16'hFFF9};
   always #25 ref_clk_in = ~ref_clk_in;
   operand_field_decode i_dut (.ref_clk_in, .rst_in, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .core_reset_req_out(trap));
   axi_lite_master_model i_bus (.clk_in(ref_clk_in), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // ctrl reset value, unmapped read and read-only write
   task automatic t_regs();
      i_bus.rd(`REG_CTRL, d, r);
      chk("ctrl", 32'h0, {d[31:2], r});
      i_bus.rd(8'h3C, d, r);
      chk("unmapped", 32'h2, {d[31:2], r});
      i_bus.wr(`REG_EXP_OUT, 32'hFFFF_FFFF, r);
      chk("ro write", 32'h2, {30'h0, r});
   endtask
   // exponent over the scaling table
   task automatic t_exp();
      for (int i = 0; i < 8; i++) begin
         i_bus.wr(`REG_OPERAND, {16'h0, ops[i]}, r);
         i_bus.rd(`REG_EXP_OUT, d, r);
         chk("exponent", {16'h0, exps[i]}, {16'h0, d[15:0]});
      end
   endtask
   // field decode and destination-mode trap
   task automatic t_decode(input logic [31:0] ins, input logic [7:0] e, input logic t);
      i_bus.wr(`REG_INSTR_LO, ins, r);
      i_bus.rd(`REG_CTL_OUT, d, r);
      chk("ctl", {24'h0, e}, {24'h0, d[7:0]});
      @(negedge ref_clk_in);
      chk("trap", {31'h0, t}, {31'h0, trap});
   endtask
   // absolute target with zero low bit
   task automatic t_target();
      i_bus.wr(`REG_INSTR_HI, 32'hFF, r);
      i_bus.wr(`REG_INSTR_LO, 32'hFFFF, r);
      i_bus.rd(`REG_PREFETCH_OUT, d, r);
      chk("target", 32'h007F_FFFE, d);
   endtask
   // guard-byte exponent, left shift and rounded store on accumulator A
   task automatic t_acc();
      i_bus.wr(`REG_ACC_A_LO, 32'h1234_8000, r);
      i_bus.wr(`REG_ACC_A_HI, 32'h80, r);
      i_bus.wr(`REG_CTRL, 32'h1, r);
      i_bus.rd(`REG_EXP_OUT, d, r);
      chk("guard exp", 32'hFFF8, {16'h0, d[15:0]});
      i_bus.rd(`REG_SHIFT_OUT, d, r);
      chk("shift", 32'h3480_0000, d);
      i_bus.rd(`REG_STORE_OUT, d, r);
      chk("store", 32'h1235, {16'h0, d[15:0]});
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a hung handshake ends the run
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_exp();
      t_decode(32'hE7C0, 8'hFF, 1'b0);
      t_decode(32'h3000, 8'h08, 1'b1);
      t_decode(32'h2800, 8'h08, 1'b0);
      t_target();
      t_acc();
      summarize();
   end
endmodule
`default_nettype wire
